// ---- hdl/psd_product_sum_datapath.sv ----
`timescale 1ns/1ns
// Function
// - 32-bit running sum, read and written by instructions
// - 16-bit filter on multiply-accumulate load addresses
// - 8-bit status and configuration register
// - flags follow final product-plus-sum result
// - multiply, then add or subtract into sum
// - product shifted left, right or not
// - optional saturation for signed and unsigned
// - signed, unsigned or fractional operand interpretation
// - 16x16 array, longwords reuse it
// - longword integer gives low 32 product bits
// - longword fraction: 63-bit product, truncate or round-even
// - three stages; issue every 1, 3, 4 clocks
// - sums stay internal; move copies them out
// - each word input picks upper or lower half
// - 4-bit mode field in status register
// - negative, zero and overflow flags
// - accumulate with parallel memory operand load
// - signed and unsigned integer multiply
// - load sum from value; store sum out
// - copy status into condition code register
// - load filter from value; store filter out
// - fraction sign in top bit, fixed extremes
module psd_product_sum_datapath (
  input wire logic mclk,
  input wire logic reset,
  input wire logic clkEn,
  input wire logic issueValid,
  input wire psd_pkg::psd_instr_t issueInstr,
  output logic issueReady_r,
  output logic resultValid_r,
  output logic [psd_pkg::SUM_W-1:0] resultData_r,
  output logic ccrValid_r,
  output logic [psd_pkg::STAT_W-1:0] ccrData_r,
  output logic loadReq_r,
  output logic [psd_pkg::SUM_W-1:0] loadAddr_r
);

  psd_pkg::psd_stage_t s1_r;
  psd_pkg::psd_stage_t s1_nxt;
  psd_pkg::psd_stage_t s2_r;
  psd_pkg::psd_stage_t s2_nxt;
  logic issueReady_nxt;
  logic loadReq_nxt;
  logic [psd_pkg::SUM_W-1:0] loadAddr_nxt;
  logic accept;
  logic s1Done;
  logic [1:0] lastOfIssue;
  logic [psd_pkg::HALF_W-1:0] xWord;
  logic [psd_pkg::HALF_W-1:0] yWord;
  logic [psd_pkg::HALF_W-1:0] mulA;
  logic [psd_pkg::HALF_W-1:0] mulB;
  logic mulASigned;
  logic mulBSigned;
  logic wordSigned;
  logic [psd_pkg::PROD_W-1:0] prod;

  logic [psd_pkg::SUM_W-1:0] sum_r;
  logic [psd_pkg::SUM_W-1:0] sum_nxt;
  logic [psd_pkg::FILT_W-1:0] filt_r;
  logic [psd_pkg::FILT_W-1:0] filt_nxt;
  logic [psd_pkg::STAT_W-1:0] stat_r;
  logic [psd_pkg::STAT_W-1:0] stat_nxt;
  logic [psd_pkg::WIDE_W-1:0] prodAcc_r;
  logic [psd_pkg::WIDE_W-1:0] prodAcc_nxt;
  logic resultValid_nxt;
  logic [psd_pkg::SUM_W-1:0] resultData_nxt;
  logic ccrValid_nxt;
  logic [psd_pkg::STAT_W-1:0] ccrData_nxt;

  logic [psd_pkg::WIDE_W-1:0] ppExt;
  logic [psd_pkg::WIDE_W-1:0] ppShifted;
  logic [psd_pkg::WIDE_W-1:0] full;
  logic [psd_pkg::WIDE_W-1:0] fracAligned;
  logic roundUp;
  logic [psd_pkg::SUM_W-1:0] prod32;
  logic [psd_pkg::SUM_W-1:0] prodShifted;
  logic accSigned;
  logic [psd_pkg::SUM_W:0] addA;
  logic [psd_pkg::SUM_W:0] addB;
  logic [psd_pkg::SUM_W:0] sum33;
  logic overflow;
  logic [psd_pkg::SUM_W-1:0] clampVal;
  logic [psd_pkg::SUM_W-1:0] newSum;
  logic s2Last;

  // issue and pass sequencing
  always_comb begin
    accept = issueValid && issueReady_r;
    s1Done = s1_r.valid && (s1_r.idx == s1_r.last);
    // longwords other than sum loads take extra passes through the one array
    if (issueInstr.isLong && (issueInstr.op != psd_pkg::PSD_OP_LD_SUM)) begin
      if (issueInstr.op == psd_pkg::PSD_OP_MAC && stat_r[psd_pkg::ST_FRAC]) begin
        lastOfIssue = psd_pkg::LAST_LONG_FRAC;
      end else begin
        lastOfIssue = psd_pkg::LAST_LONG_INT;
      end
    end else begin
      lastOfIssue = psd_pkg::LAST_WORD;
    end
    s1_nxt = s1_r;
    if (s1_r.valid && !s1Done) begin
      s1_nxt.idx = s1_r.idx + 2'h1;
    end else if (accept) begin
      s1_nxt.valid = 1'b1;
      s1_nxt.instr = issueInstr;
      s1_nxt.idx = 2'h0;
      s1_nxt.last = lastOfIssue;
    end else begin
      s1_nxt.valid = 1'b0;
    end
    s2_nxt = s1_r;
    // a mode change must land before the next op picks its signedness
    issueReady_nxt = (!s1_nxt.valid || (s1_nxt.idx == s1_nxt.last)) &&
                     !(s1_nxt.valid && s1_nxt.instr.op == psd_pkg::PSD_OP_LD_STAT) &&
                     !(s1_r.valid && s1_r.instr.op == psd_pkg::PSD_OP_LD_STAT);
    // memory operand fetch runs beside the multiply
    loadReq_nxt = accept && issueInstr.withLoad && (issueInstr.op == psd_pkg::PSD_OP_MAC);
    loadAddr_nxt = loadAddr_r;
    if (loadReq_nxt) begin
      loadAddr_nxt = issueInstr.loadAddr;
      if (issueInstr.useFilter) begin
        loadAddr_nxt[psd_pkg::FILT_W-1:0] = issueInstr.loadAddr[psd_pkg::FILT_W-1:0] & filt_r;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      s1_r <= '0;
      s2_r <= '0;
      issueReady_r <= 1'b0;
      loadReq_r <= 1'b0;
      loadAddr_r <= '0;
    end else if (clkEn) begin
      s1_r <= s1_nxt;
      s2_r <= s2_nxt;
      issueReady_r <= issueReady_nxt;
      loadReq_r <= loadReq_nxt;
      loadAddr_r <= loadAddr_nxt;
    end
  end

  // operand selection into the array
  always_comb begin
    xWord = s1_r.instr.upperX ? s1_r.instr.opX[31:16] : s1_r.instr.opX[15:0];
    yWord = s1_r.instr.upperY ? s1_r.instr.opY[31:16] : s1_r.instr.opY[15:0];
    unique case (s1_r.instr.op)
      psd_pkg::PSD_OP_MULS: wordSigned = 1'b1;
      psd_pkg::PSD_OP_MULU: wordSigned = 1'b0;
      default: wordSigned = !stat_r[psd_pkg::ST_UNS] || stat_r[psd_pkg::ST_FRAC];
    endcase
    if (s1_r.instr.isLong) begin
      // pass order: lo*lo, lo*hi, hi*lo, hi*hi; only fractions need hi*hi
      mulA = s1_r.idx[1] ? s1_r.instr.opX[31:16] : s1_r.instr.opX[15:0];
      mulB = s1_r.idx[0] ? s1_r.instr.opY[31:16] : s1_r.instr.opY[15:0];
      // upper halves signed only where the full product matters
      mulASigned = s1_r.idx[1] && (s1_r.last == psd_pkg::LAST_LONG_FRAC);
      mulBSigned = s1_r.idx[0] && (s1_r.last == psd_pkg::LAST_LONG_FRAC);
    end else begin
      mulA = xWord;
      mulB = yWord;
      mulASigned = wordSigned;
      mulBSigned = wordSigned;
    end
  end

  psd_mul17 u_mul (
    .mclk(mclk),
    .reset(reset),
    .clkEn(clkEn),
    .a(mulA),
    .b(mulB),
    .aSigned(mulASigned),
    .bSigned(mulBSigned),
    .prod_r(prod)
  );

  // final stage: combine, accumulate, commit
  always_comb begin
    s2Last = s2_r.valid && (s2_r.idx == s2_r.last);
    ppExt = {{(psd_pkg::WIDE_W - psd_pkg::PROD_W){prod[psd_pkg::PROD_W-1]}}, prod};
    unique case (s2_r.idx)
      2'h0: ppShifted = ppExt;
      2'h3: ppShifted = ppExt << 32;
      default: ppShifted = ppExt << 16;
    endcase
    full = ((s2_r.idx == 2'h0) ? '0 : prodAcc_r) + ppShifted;
    prodAcc_nxt = s2_r.valid ? full : prodAcc_r;

    // fractions align the binary point by one place
    fracAligned = full << 1;
    roundUp = stat_r[psd_pkg::ST_RND] && fracAligned[31] &&
              ((|fracAligned[30:0]) || fracAligned[32]);
    if (s2_r.instr.op == psd_pkg::PSD_OP_MAC && stat_r[psd_pkg::ST_FRAC]) begin
      if (s2_r.instr.isLong) begin
        prod32 = fracAligned[63:32] + {31'h0, roundUp};
      end else begin
        prod32 = fracAligned[31:0];
      end
    end else begin
      prod32 = full[31:0];
    end

    accSigned = !stat_r[psd_pkg::ST_UNS] || stat_r[psd_pkg::ST_FRAC];
    unique case (s2_r.instr.shift)
      psd_pkg::PSD_SH_LEFT: prodShifted = prod32 << 1;
      psd_pkg::PSD_SH_RIGHT: prodShifted = {accSigned & prod32[31], prod32[31:1]};
      default: prodShifted = prod32;
    endcase

    addA = {accSigned & sum_r[31], sum_r};
    addB = {accSigned & prodShifted[31], prodShifted};
    sum33 = s2_r.instr.subtract ? (addA - addB) : (addA + addB);
    overflow = accSigned ? (sum33[32] ^ sum33[31]) : sum33[32];
    if (accSigned) begin
      clampVal = sum33[32] ? psd_pkg::SIGNED_MIN : psd_pkg::SIGNED_MAX;
    end else begin
      clampVal = s2_r.instr.subtract ? psd_pkg::UNSIGNED_MIN : psd_pkg::UNSIGNED_MAX;
    end
    newSum = (overflow && stat_r[psd_pkg::ST_SAT]) ? clampVal : sum33[31:0];

    sum_nxt = sum_r;
    filt_nxt = filt_r;
    stat_nxt = stat_r;
    resultValid_nxt = 1'b0;
    resultData_nxt = resultData_r;
    ccrValid_nxt = 1'b0;
    ccrData_nxt = ccrData_r;
    if (s2Last) begin
      unique case (s2_r.instr.op)
        psd_pkg::PSD_OP_MAC: begin
          sum_nxt = newSum;
          stat_nxt[psd_pkg::ST_NEG] = newSum[31];
          stat_nxt[psd_pkg::ST_ZERO] = (newSum == '0);
          // overflow is sticky until software reloads the status
          stat_nxt[psd_pkg::ST_OVF] = stat_r[psd_pkg::ST_OVF] | overflow;
        end
        psd_pkg::PSD_OP_MULS,
        psd_pkg::PSD_OP_MULU: begin
          resultValid_nxt = 1'b1;
          resultData_nxt = prod32;
        end
        psd_pkg::PSD_OP_LD_SUM: sum_nxt = s2_r.instr.opY;
        psd_pkg::PSD_OP_ST_SUM: begin
          resultValid_nxt = 1'b1;
          resultData_nxt = sum_r;
        end
        psd_pkg::PSD_OP_LD_STAT: stat_nxt = s2_r.instr.opY[7:0] & psd_pkg::STAT_WMASK;
        psd_pkg::PSD_OP_ST_STAT: begin
          resultValid_nxt = 1'b1;
          resultData_nxt = {24'h0, stat_r};
        end
        psd_pkg::PSD_OP_STAT_CCR: begin
          ccrValid_nxt = 1'b1;
          ccrData_nxt = stat_r;
        end
        psd_pkg::PSD_OP_LD_FILT: filt_nxt = s2_r.instr.opY[15:0];
        psd_pkg::PSD_OP_ST_FILT: begin
          resultValid_nxt = 1'b1;
          resultData_nxt = {16'h0, filt_r};
        end
        default: begin
          resultValid_nxt = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      sum_r <= psd_pkg::SUM_RST;
      filt_r <= psd_pkg::FILT_RST;
      stat_r <= psd_pkg::STAT_RST;
      prodAcc_r <= '0;
      resultValid_r <= 1'b0;
      resultData_r <= '0;
      ccrValid_r <= 1'b0;
      ccrData_r <= '0;
    end else if (clkEn) begin
      sum_r <= sum_nxt;
      filt_r <= filt_nxt;
      stat_r <= stat_nxt;
      prodAcc_r <= prodAcc_nxt;
      resultValid_r <= resultValid_nxt;
      resultData_r <= resultData_nxt;
      ccrValid_r <= ccrValid_nxt;
      ccrData_r <= ccrData_nxt;
    end
  end

endmodule : psd_product_sum_datapath

// ---- hdl/psd_pkg.sv ----
package psd_pkg;

  // widths
  localparam int SUM_W = 32;
  localparam int FILT_W = 16;
  localparam int STAT_W = 8;
  localparam int HALF_W = 16;
  localparam int PROD_W = 34;
  localparam int WIDE_W = 64;

  // status register field positions
  localparam int ST_SAT = 7;
  localparam int ST_UNS = 6;
  localparam int ST_FRAC = 5;
  localparam int ST_RND = 4;
  localparam int ST_NEG = 3;
  localparam int ST_ZERO = 2;
  localparam int ST_OVF = 1;

  // reset values
  localparam logic [SUM_W-1:0] SUM_RST = 32'h0000_0000;
  localparam logic [FILT_W-1:0] FILT_RST = 16'hffff;
  localparam logic [STAT_W-1:0] STAT_RST = 8'h00;
  // bit 0 is reserved and reads as zero
  localparam logic [STAT_W-1:0] STAT_WMASK = 8'hfe;

  // clamp values
  localparam logic [SUM_W-1:0] SIGNED_MAX = 32'h7fff_ffff;
  localparam logic [SUM_W-1:0] SIGNED_MIN = 32'h8000_0000;
  localparam logic [SUM_W-1:0] UNSIGNED_MAX = 32'hffff_ffff;
  localparam logic [SUM_W-1:0] UNSIGNED_MIN = 32'h0000_0000;

  // index of the last multiplier pass per operation kind
  localparam logic [1:0] LAST_WORD = 2'h0;
  localparam logic [1:0] LAST_LONG_INT = 2'h2;
  localparam logic [1:0] LAST_LONG_FRAC = 2'h3;

  typedef enum logic [3:0] {
    PSD_OP_MAC,
    PSD_OP_MULS,
    PSD_OP_MULU,
    PSD_OP_LD_SUM,
    PSD_OP_ST_SUM,
    PSD_OP_LD_STAT,
    PSD_OP_ST_STAT,
    PSD_OP_STAT_CCR,
    PSD_OP_LD_FILT,
    PSD_OP_ST_FILT
  } psd_op_t;

  typedef enum logic [1:0] {
    PSD_SH_NONE,
    PSD_SH_LEFT,
    PSD_SH_RIGHT
  } psd_shift_t;

  typedef struct packed {
    psd_op_t op;
    logic isLong;
    logic subtract;
    psd_shift_t shift;
    logic upperX;
    logic upperY;
    logic withLoad;
    logic useFilter;
    logic [SUM_W-1:0] opX;
    logic [SUM_W-1:0] opY;
    logic [SUM_W-1:0] loadAddr;
  } psd_instr_t;

  typedef struct packed {
    logic valid;
    psd_instr_t instr;
    logic [1:0] idx;
    logic [1:0] last;
  } psd_stage_t;

endpackage : psd_pkg

// ---- hdl/psd_mul17.sv ----
`timescale 1ns/1ns
// one registered pass of the shared 16x16 array
module psd_mul17 (
  input wire logic mclk,
  input wire logic reset,
  input wire logic clkEn,
  input wire logic [psd_pkg::HALF_W-1:0] a,
  input wire logic [psd_pkg::HALF_W-1:0] b,
  input wire logic aSigned,
  input wire logic bSigned,
  output logic [psd_pkg::PROD_W-1:0] prod_r
);

  logic signed [psd_pkg::HALF_W:0] aExt;
  logic signed [psd_pkg::HALF_W:0] bExt;
  logic [psd_pkg::PROD_W-1:0] prod_nxt;

  always_comb begin
    // 17-bit extension lets one signed array serve both formats
    aExt = signed'({aSigned & a[psd_pkg::HALF_W-1], a});
    bExt = signed'({bSigned & b[psd_pkg::HALF_W-1], b});
    // widen before the multiply so no tool keeps only 17 product bits
    prod_nxt = psd_pkg::PROD_W'(aExt) * psd_pkg::PROD_W'(bExt);
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      prod_r <= '0;
    end else if (clkEn) begin
      prod_r <= prod_nxt;
    end
  end

endmodule : psd_mul17

// ---- tb/psd_product_sum_datapath_props.sv ----
`timescale 1ns/1ns
module psd_product_sum_datapath_props (
  input wire logic mclk,
  input wire logic reset,
  input wire logic clkEn,
  input wire logic issueValid,
  input wire psd_pkg::psd_instr_t issueInstr,
  input wire logic issueReady_r,
  input wire logic resultValid_r,
  input wire logic [psd_pkg::SUM_W-1:0] resultData_r,
  input wire logic ccrValid_r,
  input wire logic [psd_pkg::STAT_W-1:0] ccrData_r,
  input wire logic loadReq_r,
  input wire logic [psd_pkg::SUM_W-1:0] loadAddr_r
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  wire logic take = issueValid && issueReady_r && clkEn;
  wire psd_pkg::psd_op_t op = issueInstr.op;
  wire logic ldTake = take && op == psd_pkg::PSD_OP_MAC && issueInstr.withLoad;
  wire logic [31:0] ldA = issueInstr.loadAddr;
  AST_RESET_QUIET: assert property (disable iff (1'b0) reset |=>
    !issueReady_r && !resultValid_r && !ccrValid_r && !loadReq_r) else $error("outputs active after reset");
  AST_LOAD_REQ: assert property (ldTake |=> loadReq_r) else $error("no load request");
  // frozen flops keep the pulse while clkEn is low
  AST_NO_LOAD: assert property (clkEn && !ldTake |=> !loadReq_r) else $error("stray load request");
  AST_LOAD_HI: assert property (ldTake |=> loadAddr_r[31:16] == $past(ldA[31:16]))
    else $error("upper load address altered");
  AST_LOAD_RAW: assert property (ldTake && !issueInstr.useFilter |=> loadAddr_r == $past(ldA))
    else $error("unfiltered load address altered");
  AST_LONG_MUL_GAP: assert property (take && issueInstr.isLong &&
    (op == psd_pkg::PSD_OP_MULS || op == psd_pkg::PSD_OP_MULU) |=> !issueReady_r [*2])
    else $error("longword multiply issued too fast");
  AST_LONG_MAC_GAP: assert property (take && issueInstr.isLong && op == psd_pkg::PSD_OP_MAC
    |=> !issueReady_r [*2]) else $error("longword accumulate issued too fast");
  AST_STAT_LOAD_GAP: assert property (take && op == psd_pkg::PSD_OP_LD_STAT |=> !issueReady_r [*2])
    else $error("status load not followed by stall");
  AST_WORD_RATE: assert property (take && !issueInstr.isLong && op == psd_pkg::PSD_OP_MAC |=> issueReady_r)
    else $error("word accumulate stalled issue");
  AST_MUL_ANSWER: assert property (take && !issueInstr.isLong && op == psd_pkg::PSD_OP_MULS
    |-> ##[2:4] resultValid_r) else $error("multiply result missing");
  AST_CCR_ANSWER: assert property (take && op == psd_pkg::PSD_OP_STAT_CCR
    |-> ##[2:4] ccrValid_r && ccrData_r[0] == 1'b0) else $error("status copy missing");
endmodule : psd_product_sum_datapath_props
bind psd_product_sum_datapath psd_product_sum_datapath_props u_psd_product_sum_datapath_props (
  .mclk(mclk), .reset(reset), .clkEn(clkEn), .issueValid(issueValid), .issueInstr(issueInstr),
  .issueReady_r(issueReady_r), .resultValid_r(resultValid_r), .resultData_r(resultData_r),
  .ccrValid_r(ccrValid_r), .ccrData_r(ccrData_r), .loadReq_r(loadReq_r), .loadAddr_r(loadAddr_r)
);

// ---- tb/psd_core_model.sv ----
`timescale 1ns/1ns
module psd_core_model (
  input wire logic mclk,
  input wire logic clkEn,
  input wire logic issueReady_r,
  output logic issueValid,
  output psd_pkg::psd_instr_t issueInstr
);
  initial begin
    issueValid = 1'b0;
    issueInstr = '0;
  end
  // request held until taken at an enabled edge
  task automatic issue(input psd_pkg::psd_instr_t i);
    @(negedge mclk);
    issueValid = 1'b1;
    issueInstr = i;
    do @(posedge mclk); while (!(issueReady_r && clkEn));
  endtask : issue
  // released lines show inverted stale data, never the last value
  task automatic idle();
    @(negedge mclk);
    issueValid = 1'b0;
    issueInstr = ~issueInstr;
  endtask : idle
endmodule : psd_core_model

// ---- tb/psd_product_sum_datapath_bench.sv ----
`timescale 1ns/1ns
module psd_product_sum_datapath_bench;
  logic mclk;
  logic reset;
  logic clkEn;
  logic issueValid;
  psd_pkg::psd_instr_t issueInstr;
  psd_pkg::psd_instr_t t;
  logic issueReady_r, resultValid_r, ccrValid_r, loadReq_r;
  logic [31:0] resultData_r, loadAddr_r, d;
  logic [7:0] ccrData_r;
  int fails;
  int checked;
  time tk;
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  psd_product_sum_datapath u_psd_product_sum_datapath (.mclk(mclk), .reset(reset), .clkEn(clkEn),
    .issueValid(issueValid), .issueInstr(issueInstr), .issueReady_r(issueReady_r),
    .resultValid_r(resultValid_r), .resultData_r(resultData_r), .ccrValid_r(ccrValid_r),
    .ccrData_r(ccrData_r), .loadReq_r(loadReq_r), .loadAddr_r(loadAddr_r));
  psd_core_model u_psd_core_model (.mclk(mclk), .clkEn(clkEn), .issueReady_r(issueReady_r),
    .issueValid(issueValid), .issueInstr(issueInstr));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  function automatic psd_pkg::psd_instr_t mk(input psd_pkg::psd_op_t op, input logic [31:0] x, input logic [31:0] y);
    mk = '0;
    mk.op = op;
    mk.opX = x;
    mk.opY = y;
  endfunction : mk
  // f = {subtract, shift[1:0], upperX, upperY}
  function automatic psd_pkg::psd_instr_t mac(input logic [31:0] x, input logic [31:0] y, input logic [4:0] f);
    mac = mk(psd_pkg::PSD_OP_MAC, x, y);
    mac.subtract = f[4];
    mac.shift = psd_pkg::psd_shift_t'(f[3:2]);
    mac.upperX = f[1];
    mac.upperY = f[0];
  endfunction : mac
  task automatic doOp(input psd_pkg::psd_instr_t i);
    u_psd_core_model.issue(i);
    u_psd_core_model.idle();
  endtask : doOp
  // a missed pulse leaves x, which never matches
  task automatic getOut(input logic condition_code_reg, output logic [31:0] v);
    v = 'x;
    for (int n = 0; n < 12; n++) begin
      @(negedge mclk);
      if (condition_code_reg ? ccrValid_r === 1'b1 : resultValid_r === 1'b1) begin
        v = condition_code_reg ? {24'h0, ccrData_r} : resultData_r;
        break;
      end
    end
  endtask : getOut
  task automatic rd(input psd_pkg::psd_op_t op, input logic [31:0] exp);
    doOp(mk(op, 0, 0));
    getOut(op == psd_pkg::PSD_OP_STAT_CCR, d);
    chk(d, exp);
  endtask : rd
  task automatic ld(input psd_pkg::psd_op_t op, input logic [31:0] v);
    doOp(mk(op, 0, v));
  endtask : ld
  task automatic mul(input psd_pkg::psd_op_t op, input logic [31:0] x, y, input logic lng, input logic [31:0] exp);
    psd_pkg::psd_instr_t i;
    i = mk(op, x, y);
    i.isLong = lng;
    doOp(i);
    getOut(1'b0, d);
    chk(d, exp);
  endtask : mul
  task automatic print_verdict();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : print_verdict
  initial begin
    repeat (5000) @(posedge mclk);
    fails++;
    print_verdict();
  end
  initial begin
    fails = 0;
    checked = 0;
    reset = 1'b1;
    clkEn = 1'b1;
    repeat (6) @(negedge mclk);
    reset = 1'b0;
    rd(psd_pkg::PSD_OP_ST_SUM, 0);
    rd(psd_pkg::PSD_OP_ST_FILT, 32'h0000_ffff);
    rd(psd_pkg::PSD_OP_ST_STAT, 0);
    rd(psd_pkg::PSD_OP_STAT_CCR, 0);
    $display("test reset values done");
    ld(psd_pkg::PSD_OP_LD_SUM, 32'h1234_5678);
    @(negedge mclk);
    clkEn = 1'b0;
    repeat (4) @(negedge mclk);
    clkEn = 1'b1;
    rd(psd_pkg::PSD_OP_ST_SUM, 32'h1234_5678);
    ld(psd_pkg::PSD_OP_LD_FILT, 32'h0000_00ff);
    rd(psd_pkg::PSD_OP_ST_FILT, 32'h0000_00ff);
    $display("test moves done");
    ld(psd_pkg::PSD_OP_LD_SUM, 32'h0000_000a);
    u_psd_core_model.issue(mac(32'h0003_fffe, 32'h0003_fffe, 5'b0_00_10));
    u_psd_core_model.issue(mac(32'h0003_fffe, 32'h0003_fffe, 5'b1_01_10));
    u_psd_core_model.issue(mac(32'h0000_0008, 32'h0003_0000, 5'b0_10_01));
    u_psd_core_model.idle();
    rd(psd_pkg::PSD_OP_ST_SUM, 32'h0000_001c);
    rd(psd_pkg::PSD_OP_ST_STAT, 0);
    ld(psd_pkg::PSD_OP_LD_SUM, 0);
    doOp(mac(1, 0, 5'b0));
    rd(psd_pkg::PSD_OP_ST_STAT, 32'h04);
    rd(psd_pkg::PSD_OP_STAT_CCR, 32'h04);
    doOp(mac(1, 1, 5'b1_00_00));
    rd(psd_pkg::PSD_OP_ST_SUM, 32'hffff_ffff);
    rd(psd_pkg::PSD_OP_ST_STAT, 32'h08);
    $display("test accumulate done");
    ld(psd_pkg::PSD_OP_LD_STAT, 32'h80);
    ld(psd_pkg::PSD_OP_LD_SUM, 32'h7fff_ffff);
    doOp(mac(1, 1, 5'b0));
    rd(psd_pkg::PSD_OP_ST_SUM, 32'h7fff_ffff);
    rd(psd_pkg::PSD_OP_ST_STAT, 32'h82);
    ld(psd_pkg::PSD_OP_LD_STAT, 32'hc0);
    ld(psd_pkg::PSD_OP_LD_SUM, 32'hffff_fff0);
    doOp(mac(32'hffff, 32'hffff, 5'b0));
    rd(psd_pkg::PSD_OP_ST_SUM, 32'hffff_ffff);
    ld(psd_pkg::PSD_OP_LD_SUM, 0);
    doOp(mac(2, 3, 5'b1_00_00));
    rd(psd_pkg::PSD_OP_ST_SUM, 0);
    ld(psd_pkg::PSD_OP_LD_STAT, 32'h20);
    ld(psd_pkg::PSD_OP_LD_SUM, 0);
    doOp(mac(32'h4000, 32'h4000, 5'b0));
    rd(psd_pkg::PSD_OP_ST_SUM, 32'h2000_0000);
    $display("test modes done");
    mul(psd_pkg::PSD_OP_MULS, 32'hffff, 2, 1'b0, 32'hffff_fffe);
    mul(psd_pkg::PSD_OP_MULU, 32'hffff, 2, 1'b0, 32'h0001_fffe);
    mul(psd_pkg::PSD_OP_MULS, 32'h1_0000, 32'h1_0001, 1'b1, 32'h0001_0000);
    mul(psd_pkg::PSD_OP_MULU, 32'h1_0003, 32'h1_0000, 1'b1, 32'h0003_0000);
    $display("test multiply done");
    ld(psd_pkg::PSD_OP_LD_STAT, 32'h80);
    ld(psd_pkg::PSD_OP_LD_SUM, 32'h8000_0000);
    doOp(mac(1, 1, 5'b1_00_00));
    rd(psd_pkg::PSD_OP_ST_SUM, 32'h8000_0000);
    ld(psd_pkg::PSD_OP_LD_STAT, 32'h30);
    ld(psd_pkg::PSD_OP_LD_SUM, 0);
    t = mac(3, 32'h4000_0000, 5'b0);
    t.isLong = 1'b1;
    u_psd_core_model.issue(t);
    tk = $time;
    u_psd_core_model.issue(t);
    chk(32'(($time - tk) / 50), 4);
    u_psd_core_model.idle();
    rd(psd_pkg::PSD_OP_ST_SUM, 32'h0000_0004);
    rd(psd_pkg::PSD_OP_ST_STAT, 32'h30);
    ld(psd_pkg::PSD_OP_LD_STAT, 32'h20);
    ld(psd_pkg::PSD_OP_LD_SUM, 0);
    doOp(t);
    rd(psd_pkg::PSD_OP_ST_SUM, 32'h0000_0001);
    ld(psd_pkg::PSD_OP_LD_STAT, 0);
    ld(psd_pkg::PSD_OP_LD_SUM, 0);
    t = mac(32'h1_0000, 32'h1_0001, 5'b0);
    t.isLong = 1'b1;
    u_psd_core_model.issue(t);
    tk = $time;
    u_psd_core_model.issue(t);
    chk(32'(($time - tk) / 50), 3);
    u_psd_core_model.idle();
    rd(psd_pkg::PSD_OP_ST_SUM, 32'h0002_0000);
    $display("test long accumulate done");
    t = mac(0, 0, 5'b0);
    t.withLoad = 1'b1;
    t.useFilter = 1'b1;
    t.loadAddr = 32'habcd_1234;
    doOp(t);
    chk({31'h0, loadReq_r}, 1);
    chk(loadAddr_r, 32'habcd_0034);
    t.useFilter = 1'b0;
    doOp(t);
    chk(loadAddr_r, 32'habcd_1234);
    $display("test load done");
    print_verdict();
  end
endmodule : psd_product_sum_datapath_bench
